// ==== bench/glitch_regs_sva.sv ====
`timescale 1ns/10ps
`default_nettype none

module glitch_regs_sva (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   // Write channels
   input  wire logic [7:0]  awaddr_in,
   input  wire logic        awvalid_in,
   input  wire logic        awready_out,
   input  wire logic        wvalid_in,
   input  wire logic        wready_out,
   input  wire logic        bvalid_out,
   // Read channels
   input  wire logic [7:0]  araddr_in,
   input  wire logic        arvalid_in,
   input  wire logic        arready_out,
   input  wire logic [31:0] rdata_out,
   input  wire logic [1:0]  rresp_out,
   input  wire logic        rvalid_out,
   input  wire logic        rready_in,
   // Pads and filtered lines
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        scl_filt_out,
   input  wire logic        sda_filt_out
);
   // Expected build word, field by field
   localparam logic [31:0] BUILD = {8'h00, 8'h0f, 8'h0f, 4'b1110, 2'h3, 2'h2};
   logic [7:0] ar_q;  // Address of the read in flight
   logic       lw_q;  // A limit write was taken since reset

   // ****************************************************************
   // Helper state
   // ****************************************************************
   // Remember the read address so the answer can be judged
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ar_q <= 8'h00;
      end else if (arvalid_in && arready_out) begin
         ar_q <= araddr_in;
      end
   end
   // Reset values are only judged until the first limit write
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lw_q <= 1'b0;
      end else if (awvalid_in && awready_out && awaddr_in[7:4] == 4'ha) begin
         lw_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);

   a_write_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out
      |=> ##1 bvalid_out) else $error("write response late");
   a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
      else $error("read response late");
   a_read_stands: assert property (rvalid_out && !rready_in
      |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out)) else $error("read data moved");
   a_build_const: assert property (rvalid_out && ar_q == 8'hf4
      |-> rdata_out == BUILD && rresp_out == 2'h0) else $error("build word wrong");
   a_limit_clamp: assert property (rvalid_out && ar_q[7:4] == 4'ha && !ar_q[3]
      |-> rdata_out[31:8] == 24'h0 && rdata_out[7:0] >= 8'h02) else $error("limit bad");
   a_reset_limits: assert property (rvalid_out && !lw_q && ar_q[7:3] == 5'h14
      |-> rdata_out == (ar_q[2] ? 32'h2 : 32'h6)) else $error("limit reset value wrong");
   // Lowest limit is two, so any change must rest on equal pad samples taken three and four cycles back
   a_scl_spike: assert property ($changed(scl_filt_out)
      |-> $past(scl_in, 3) == scl_filt_out && $past(scl_in, 4) == scl_filt_out)
      else $error("scl spike passed");
   a_sda_spike: assert property ($changed(sda_filt_out)
      |-> $past(sda_in, 3) == sda_filt_out && $past(sda_in, 4) == sda_filt_out)
      else $error("sda spike passed");

   c_scl_pass: cover property ($fell(scl_filt_out));
   c_sda_pass: cover property ($fell(sda_filt_out));
   c_slverr: cover property (rvalid_out && rresp_out == 2'h2);
endmodule

bind glitch_regs_top glitch_regs_sva i_sva (.mclk_in, .arst_n_in, .awaddr_in, .awvalid_in,
   .awready_out, .wvalid_in, .wready_out, .bvalid_out, .araddr_in, .arvalid_in, .arready_out,
   .rdata_out, .rresp_out, .rvalid_out, .rready_in, .scl_in, .sda_in, .scl_filt_out,
   .sda_filt_out);

`default_nettype wire

// ==== bench/i2c_remote_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module i2c_remote_model (
   // Clock of the controller side
   input  wire logic mclk_in,
   // Pad levels, pulled up while released
   output logic      scl_out,
   output logic      sda_out
);
   // Both lines idle released
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // limits set first
   // Pulses only come when the bench asks, after both limits are settled
   task automatic pulse(input bit ln, input int len);
      @(posedge mclk_in);
      if (ln) sda_out <= 1'b0;
      else scl_out <= 1'b0;
      repeat (len) @(posedge mclk_in);
      scl_out <= 1'b1;
      sda_out <= 1'b1;
   endtask
endmodule

`default_nettype wire

// ==== bench/test_glitch_regs_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_glitch_regs_top;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [31:0] BUILD = {8'h00, 8'h0f, 8'h0f, 4'b1110, 2'h3, 2'h2};
   logic        mclk_in, arst_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
   logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic [7:0]  awaddr_in, araddr_in, v;
   logic [31:0] wdata_in, rdata_out;
   logic [3:0]  wstrb_in;
   logic [1:0]  bresp_out, rresp_out;
   logic        scl_in, sda_in, scl_filt_out, sda_filt_out, seen_low;
   logic [33:0] rd_q[$];  // Expected {resp, data}
   logic [1:0]  wr_q[$];  // Expected write response
   logic [7:0]  vals[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
   int          fail_count, checks_done;

   glitch_regs_top i_dut (.mclk_in, .arst_n_in, .awaddr_in, .awvalid_in, .awready_out,
      .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
      .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
      .scl_in, .sda_in, .scl_filt_out, .sda_filt_out);
   i2c_remote_model i_far (.mclk_in, .scl_out(scl_in), .sda_out(sda_in));

   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   function automatic logic [7:0] lim(input logic [7:0] x);
      return (x < 8'h02) ? 8'h02 : x;
   endfunction
   task automatic cmp_word(input string n, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_line(input string n, input logic e, input logic g);
      cmp_word(n, {33'h0, e}, {33'h0, g});
   endtask
   // Write; ready is sampled before the edge and the channel dropped after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw;
      @(posedge mclk_in);
      wr_q.push_back(er);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         ta = awready_out;
         tw = wready_out;
         @(posedge mclk_in);
         if (ta) awvalid_in <= 1'b0;
         if (tw) wvalid_in <= 1'b0;
      end while (awvalid_in || wvalid_in);
      do @(negedge mclk_in); while (!bvalid_out);
      @(posedge mclk_in);
      bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic ta;
      @(posedge mclk_in);
      rd_q.push_back(e);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         ta = arready_out;
         @(posedge mclk_in);
      end while (!ta);
      arvalid_in <= 1'b0;
      do @(negedge mclk_in); while (!rvalid_out);
      @(posedge mclk_in);
      rready_in <= 1'b0;
   endtask
   // Low pulse of len cycles on one line, then see if it got through
   task automatic spike(input bit ln, input int len, input bit pass);
      seen_low = 1'b0;
      i_far.pulse(ln, len);
      repeat (14) @(posedge mclk_in);
      cmp_line(ln ? "sda_filt_out" : "scl_filt_out", pass, seen_low);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Result watcher: handshakes are settled at the falling edge
   // ****************************************************************
   always @(negedge mclk_in) begin
      if (bvalid_out && bready_in) cmp_word("bresp", {32'h0, wr_q.pop_front()}, bresp_out);
      if (rvalid_out && rready_in) cmp_word("rdata", rd_q.pop_front(), {rresp_out, rdata_out});
      if (!scl_filt_out || !sda_filt_out) seen_low = 1'b1;
   end

   // Hang guard, far above the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      summarize();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, arst_n_in} = '0;
      {awaddr_in, araddr_in, wdata_in} = '0;
      wstrb_in = 4'hf;
      v = 8'($urandom(32'h9649_f7c6));
      repeat (20) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      rd(8'ha0, 34'h6);
      rd(8'ha4, 34'h2);
      rd(8'hf4, {2'h0, BUILD});
      rd(8'h10, {2'h2, 32'h0});
      rd(8'h70, 34'h3);
      $display("done: reset values");
      for (int i = 0; i < 10; i++) begin
         v = (i < 8) ? vals[i / 2] : 8'($urandom);
         wr(i[0] ? 8'ha4 : 8'ha0, {24'h0, v}, 2'h0);
         rd(i[0] ? 8'ha4 : 8'ha0, {26'h0, lim(v)});
      end
      $display("done: clamp");
      wr(8'ha0, 32'h5, 2'h0);
      wr(8'ha4, 32'h3, 2'h0);
      wr(8'h6c, 32'h1, 2'h0);
      wr(8'ha0, 32'h40, 2'h0);
      wr(8'ha4, 32'h40, 2'h0);
      rd(8'ha0, 34'h5);
      rd(8'ha4, 34'h3);
      wr(8'h6c, 32'h0, 2'h0);
      $display("done: locked writes");
      wr(8'hf4, 32'hffff_ffff, 2'h0);
      rd(8'hf4, {2'h0, BUILD});
      wr(8'h10, 32'h1, 2'h2);
      $display("done: read-only and unmapped");
      spike(1'b0, 5, 1'b0);
      spike(1'b0, 6, 1'b1);
      spike(1'b1, 5, 1'b0);
      wr(8'h6c, 32'h2, 2'h0);
      rd(8'h6c, 34'h2);
      spike(1'b1, 3, 1'b0);
      spike(1'b1, 4, 1'b1);
      spike(1'b0, 4, 1'b1);
      $display("done: spike filter");
      summarize();
   end
endmodule

`default_nettype wire

// ==== hdl/glitch_regs_defs.svh ====
`ifndef GLITCH_REGS_DEFS_SVH
`define GLITCH_REGS_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL             8'h6c
`define OFS_STATUS           8'h70
`define OFS_STD_FAST_LIMIT   8'ha0
`define OFS_HIGH_SPEED_LIMIT 8'ha4
`define OFS_BUILD_PARAM      8'hf4

// ****************************************************************
// Reset values and limit bounds
// ****************************************************************
`define RST_STD_FAST_LIMIT   8'h06
`define RST_HIGH_SPEED_LIMIT 8'h02
`define MIN_LIMIT            8'h02
`define LIMIT_W              8

// ****************************************************************
// Control and status field positions
// ****************************************************************
`define CTRL_ON_BIT          0
`define CTRL_HS_BIT          1
`define STAT_SCL_BIT         0
`define STAT_SDA_BIT         1
`define STAT_ON_BIT          2

// ****************************************************************
// Build parameter word field positions
// ****************************************************************
`define BP_TX_DEPTH_LSB      16
`define BP_RX_DEPTH_LSB      8
`define BP_ENCODED_BIT       7
`define BP_DMA_BIT           6
`define BP_INTR_BIT          5
`define BP_FIXED_SCL_BIT     4
`define BP_SPEED_LSB         2
`define BP_WIDTH_LSB         0

// ****************************************************************
// Bus response codes
// ****************************************************************
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== hdl/glitch_regs_pkg.sv ====
`default_nettype none

package glitch_regs_pkg;

   // Register selected by a bus address
   typedef enum logic [2:0] {
      SEL_CTRL,
      SEL_STATUS,
      SEL_STD_FAST,
      SEL_HIGH_SPEED,
      SEL_BUILD_PARAM,
      SEL_NONE
   } reg_sel_e;

   // Filter width shared by both files
   typedef logic [7:0] limit_t;

endpackage

`default_nettype wire

// ==== hdl/glitch_regs_top.sv ====
//
// Contract
// - Standard/fast mode drops pulses within limit
// - High-speed mode uses its own limit
// - Limits writable only while controller off
// - Written limits below two store two
// - Standard/fast limit resets to six
// - High-speed limit resets to two
// - Limit bits 31:8 reserved, read zero
// - Build parameter word constant and read-only
// - Bits 23:16 give transmit depth minus one
// - Bits 15:8 give receive depth minus one
// - Bit 7 set, else whole word zero
// - Bit 6 reports DMA handshake present
// - Bit 5 reports combined interrupt output
// - Bit 4 reports SCL counts not fixed
// - Bits 3:2 report top speed high
// - Bits 1:0 report 32-bit host bus
`timescale 1ns/10ps
`default_nettype none
`include "glitch_regs_defs.svh"

module glitch_regs_top #(
   parameter int TX_DEPTH         = 16,  // Transmit buffer entries
   parameter int RX_DEPTH         = 16,  // Receive buffer entries
   parameter bit ENCODED_PARAMS   = 1'b1,
   parameter bit HAS_DMA          = 1'b1,
   parameter bit INTR_COMBINED    = 1'b1,
   parameter bit FIXED_SCL_COUNTS = 1'b0,
   parameter int MAX_SPEED        = 3,   // 1 standard, 2 fast, 3 high
   parameter int BUS_WIDTH_CODE   = 2    // 0 8-bit, 1 16-bit, 2 32-bit
) (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   // AXI4-Lite write address
   input  wire logic [7:0]  awaddr_in,
   input  wire logic        awvalid_in,
   output logic             awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata_in,
   input  wire logic [3:0]  wstrb_in,
   input  wire logic        wvalid_in,
   output logic             wready_out,
   // AXI4-Lite write response
   output logic [1:0]       bresp_out,
   output logic             bvalid_out,
   input  wire logic        bready_in,
   // AXI4-Lite read address
   input  wire logic [7:0]  araddr_in,
   input  wire logic        arvalid_in,
   output logic             arready_out,
   // AXI4-Lite read data
   output logic [31:0]      rdata_out,
   output logic [1:0]       rresp_out,
   output logic             rvalid_out,
   input  wire logic        rready_in,
   // Bus lines from the pads
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   // Filtered bus lines
   output logic             scl_filt_out,
   output logic             sda_filt_out
);

   // ****************************************************************
   // Build parameter word
   // ****************************************************************
   localparam logic [7:0] TX_CODE = 8'(TX_DEPTH - 1);
   localparam logic [7:0] RX_CODE = 8'(RX_DEPTH - 1);
   localparam logic [1:0] SPEED_CODE = 2'(MAX_SPEED);
   localparam logic [1:0] WIDTH_CODE = 2'(BUS_WIDTH_CODE);

   localparam logic [31:0] PARAM_FIELDS =
      (32'(TX_CODE) << `BP_TX_DEPTH_LSB) |
      (32'(RX_CODE) << `BP_RX_DEPTH_LSB) |
      (32'(ENCODED_PARAMS) << `BP_ENCODED_BIT) |
      (32'(HAS_DMA) << `BP_DMA_BIT) |
      (32'(INTR_COMBINED) << `BP_INTR_BIT) |
      (32'(FIXED_SCL_COUNTS) << `BP_FIXED_SCL_BIT) |
      (32'(SPEED_CODE) << `BP_SPEED_LSB) |
      (32'(WIDTH_CODE) << `BP_WIDTH_LSB);

   localparam logic [31:0] PARAM_WORD = ENCODED_PARAMS ? PARAM_FIELDS : 32'h0000_0000;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Shared by the read and write paths so both see one map
   function automatic glitch_regs_pkg::reg_sel_e decode(input logic [7:0] addr);
      glitch_regs_pkg::reg_sel_e sel;
      sel = glitch_regs_pkg::SEL_NONE;
      case (addr)
         `OFS_CTRL:             sel = glitch_regs_pkg::SEL_CTRL;
         `OFS_STATUS:           sel = glitch_regs_pkg::SEL_STATUS;
         `OFS_STD_FAST_LIMIT:   sel = glitch_regs_pkg::SEL_STD_FAST;
         `OFS_HIGH_SPEED_LIMIT: sel = glitch_regs_pkg::SEL_HIGH_SPEED;
         `OFS_BUILD_PARAM:      sel = glitch_regs_pkg::SEL_BUILD_PARAM;
         default:               sel = glitch_regs_pkg::SEL_NONE;
      endcase
      return sel;
   endfunction

   // Clamp of a written limit to the smallest legal value
   function automatic glitch_regs_pkg::limit_t clamp_limit(input logic [7:0] value);
      return (value < `MIN_LIMIT) ? `MIN_LIMIT : value;
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   // Write channel capture
   logic                    aw_held_q;      // Write address captured
   logic [7:0]              aw_addr_q;      // Captured write address
   logic                    w_held_q;       // Write data captured
   logic [31:0]             w_data_q;       // Captured write data
   logic [3:0]              w_strb_q;       // Captured byte enables
   logic                    awready_q;      // Address channel open
   logic                    wready_q;       // Data channel open
   logic                    bvalid_q;       // Response pending
   logic [1:0]              bresp_q;        // Response code
   // Read channel
   logic                    arready_q;      // Read address channel open
   logic                    rvalid_q;       // Read data pending
   logic [31:0]             rdata_q;        // Read data
   logic [1:0]              rresp_q;        // Read response code
   // Registers
   logic                    ctrl_on_q;      // Controller on switch
   logic                    ctrl_hs_q;      // High-speed mode select
   glitch_regs_pkg::limit_t std_fast_glitch_limit_q;
   glitch_regs_pkg::limit_t high_speed_glitch_limit_q;
   // Datapath
   logic                    do_write;       // Both halves of a write held
   glitch_regs_pkg::reg_sel_e wr_sel;       // Target of the held write
   glitch_regs_pkg::limit_t active_limit;   // Limit for current mode
   logic [1:0]              pad_line;       // Raw pads
   logic [1:0]              sync1_q;        // First synchroniser stage
   logic [1:0]              sync2_q;        // Second synchroniser stage
   logic [1:0]              filt_line;      // Filter outputs

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wr_sel   = decode(aw_addr_q);
   assign pad_line = {sda_in, scl_in};

   // ****************************************************************
   // Write address channel
   // ****************************************************************
   // Address is held until the data arrives, so either order works
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         awready_q <= 1'b1;
      end else if (awvalid_in && awready_q) begin
         // Take address, close channel until the response is taken
         aw_held_q <= 1'b1;
         aw_addr_q <= awaddr_in;
         awready_q <= 1'b0;
      end else if (do_write) begin
         // Address consumed by the write
         aw_held_q <= 1'b0;
      end else if (bvalid_q && bready_in) begin
         // Reopen once the response has gone
         awready_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Write data channel
   // ****************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         wready_q <= 1'b1;
      end else if (wvalid_in && wready_q) begin
         // Take data and byte enables
         w_held_q <= 1'b1;
         w_data_q <= wdata_in;
         w_strb_q <= wstrb_in;
         wready_q <= 1'b0;
      end else if (do_write) begin
         // Data consumed by the write
         w_held_q <= 1'b0;
      end else if (bvalid_q && bready_in) begin
         // Reopen once the response has gone
         wready_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Write response channel
   // ****************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `RESP_OKAY;
      end else if (do_write) begin
         // Unmapped addresses get an error, mapped ones an okay
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_sel == glitch_regs_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q && bready_in) begin
         // Response taken
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Writable at any time; its on bit locks the limit registers
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_on_q <= 1'b0;
         ctrl_hs_q <= 1'b0;
      end else if (do_write && wr_sel == glitch_regs_pkg::SEL_CTRL && w_strb_q[0]) begin
         // Low byte carries both switches
         ctrl_on_q <= w_data_q[`CTRL_ON_BIT];
         ctrl_hs_q <= w_data_q[`CTRL_HS_BIT];
      end
   end

   // ****************************************************************
   // Standard/fast glitch limit
   // ****************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         std_fast_glitch_limit_q <= `RST_STD_FAST_LIMIT;
      end else if (do_write && wr_sel == glitch_regs_pkg::SEL_STD_FAST && w_strb_q[0]) begin
         if (!ctrl_on_q) begin
            std_fast_glitch_limit_q <= clamp_limit(w_data_q[7:0]);
         end
      end
   end

   // ****************************************************************
   // High-speed glitch limit
   // ****************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         high_speed_glitch_limit_q <= `RST_HIGH_SPEED_LIMIT;
      end else if (do_write && wr_sel == glitch_regs_pkg::SEL_HIGH_SPEED && w_strb_q[0]) begin
         if (!ctrl_on_q) begin
            high_speed_glitch_limit_q <= clamp_limit(w_data_q[7:0]);
         end
      end
   end

   // no write target
   // Parameter word writes hit no register, yet answer okay.

   // ****************************************************************
   // Read channel
   // ****************************************************************
   // Data is sampled at the address handshake and held until taken
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `RESP_OKAY;
      end else if (arvalid_in && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= `RESP_OKAY;
         case (decode(araddr_in))
            glitch_regs_pkg::SEL_CTRL: begin
               // Switch settings
               rdata_q <= 32'({ctrl_hs_q, ctrl_on_q});
            end
            glitch_regs_pkg::SEL_STATUS: begin
               // Live filtered levels and on state
               rdata_q <= 32'({ctrl_on_q, filt_line});
            end
            glitch_regs_pkg::SEL_STD_FAST: begin
               rdata_q <= 32'(std_fast_glitch_limit_q);
            end
            glitch_regs_pkg::SEL_HIGH_SPEED: begin
               rdata_q <= 32'(high_speed_glitch_limit_q);
            end
            glitch_regs_pkg::SEL_BUILD_PARAM: begin
               rdata_q <= PARAM_WORD;
            end
            default: begin
               // Unmapped: zero data and an error
               rdata_q <= 32'h0000_0000;
               rresp_q <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && rready_in) begin
         // Read data taken, reopen address channel
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Mode selection
   // ****************************************************************
   // high-speed limit
   assign active_limit = ctrl_hs_q ? high_speed_glitch_limit_q : std_fast_glitch_limit_q;

   // ****************************************************************
   // Pad synchronisers and filters
   // ****************************************************************
   // The pads are asynchronous; two flops precede the filter. The sync
   // delay adds two cycles of latency but does not shorten a spike.
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_q <= 2'b11;
         sync2_q <= 2'b11;
      end else begin
         sync1_q <= pad_line;
         sync2_q <= sync1_q;
      end
   end

   // One filter per line, both driven by the same limit
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         line_glitch_filter u_filter (
            .mclk_in   (mclk_in),
            .arst_n_in (arst_n_in),
            .line_in   (sync2_q[g]),
            .limit_in  (active_limit),
            .line_out  (filt_line[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign awready_out  = awready_q;
   assign wready_out   = wready_q;
   assign bvalid_out   = bvalid_q;
   assign bresp_out    = bresp_q;
   assign arready_out  = arready_q;
   assign rvalid_out   = rvalid_q;
   assign rdata_out    = rdata_q;
   assign rresp_out    = rresp_q;
   assign scl_filt_out = filt_line[0];
   assign sda_filt_out = filt_line[1];

endmodule

`default_nettype wire

// ==== hdl/line_glitch_filter.sv ====
`timescale 1ns/10ps
`default_nettype none

module line_glitch_filter (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  arst_n_in,
   // Synchronised line and active limit
   input  wire logic                  line_in,
   input  wire glitch_regs_pkg::limit_t limit_in,
   // Filtered line
   output logic                       line_out
);

   // ****************************************************************
   // State
   // ****************************************************************
   glitch_regs_pkg::limit_t run_q;     // Cycles the input has differed
   logic                    level_q;   // Accepted line level

   // ****************************************************************
   // Glitch rejection
   // ****************************************************************
   // A change is accepted only on the sample after it has lasted
   // limit cycles, so a pulse of limit cycles or shorter never shows.
   // The counter is cleared once it reaches the limit, so it cannot wrap.
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         // Bus lines idle high
         run_q   <= 8'h00;
         level_q <= 1'b1;
      end else if (line_in == level_q) begin
         // Input agrees again: spike over
         run_q <= 8'h00;
      end else if (run_q >= limit_in) begin
         // Change outlasted the limit
         level_q <= line_in;
         run_q   <= 8'h00;
      end else begin
         // Still inside the window
         run_q <= run_q + 8'h01;
      end
   end

   assign line_out = level_q;

endmodule

`default_nettype wire
